// [mise_pkg.sv]
// Shared constants and types for the instruction-subset execution block
package mise_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned MISE_DATA_W = 8;
  localparam int unsigned MISE_FILE_W = 7;
  localparam int unsigned MISE_LIT_W = 11;
  localparam int unsigned MISE_PC_W = 13;
  localparam int unsigned MISE_APB_AW = 8;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MISE_OFF_ACC = 8'h00;
  localparam logic [7:0] MISE_OFF_STATUS = 8'h04;
  localparam logic [7:0] MISE_OFF_ULATCH = 8'h08;
  localparam logic [7:0] MISE_OFF_PC = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MISE_STAT_ZERO_BIT = 0;
  localparam int unsigned MISE_STAT_SQUASH_BIT = 1;
  localparam int unsigned MISE_ULATCH_HI = 4;
  localparam int unsigned MISE_ULATCH_LO = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MISE_ACC_RST = 8'h00;
  localparam logic [7:0] MISE_ULATCH_RST = 8'h00;
  localparam logic [12:0] MISE_PC_RST = 13'h0000;
  localparam logic MISE_ZERO_RST = 1'b0;

  // ----------------------------------------------------------------
  // Decoded instruction codes and execution states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP,
    OP_CLEAR_FILE,
    OP_CLEAR_ACC,
    OP_DEC_FILE,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_JUMP_ABS,
    OP_OR_LIT_ACC
  } mise_op_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } mise_state_t;

endpackage

// [mise_alu.sv]
// Result, destination and flag decisions for one decoded instruction
`timescale 1ns/1ps
`default_nettype none

module mise_alu
  import mise_pkg::*;
(
  input wire mise_op_t op,
  input wire logic dest,
  input wire logic [7:0] file_val,
  input wire logic [7:0] acc_val,
  input wire logic [7:0] lit,
  output logic [7:0] result,
  output logic to_acc,
  output logic to_file,
  output logic upd_zero,
  output logic zero_val,
  output logic skip_next,
  output logic jump
);

  // ----------------------------------------------------------------
  // Per-instruction datapath
  // ----------------------------------------------------------------
  always_comb begin
    result = 8'h00;
    to_acc = 1'b0;
    to_file = 1'b0;
    upd_zero = 1'b0;
    skip_next = 1'b0;
    jump = 1'b0;
    case (op)
      OP_CLEAR_FILE: begin
        result = 8'h00;
        to_file = 1'b1;
        upd_zero = 1'b1;
      end
      OP_CLEAR_ACC: begin
        result = 8'h00;
        to_acc = 1'b1;
        upd_zero = 1'b1;
      end
      OP_DEC_FILE: begin
        result = file_val - 8'h01;
        to_acc = ~dest;
        to_file = dest;
        upd_zero = 1'b1;
      end
      OP_DEC_SKIP: begin
        result = file_val - 8'h01;
        to_acc = ~dest;
        to_file = dest;
        skip_next = (result == 8'h00);
      end
      OP_INC_SKIP: begin
        result = file_val + 8'h01;
        to_acc = ~dest;
        to_file = dest;
        skip_next = (result == 8'h00);
      end
      OP_JUMP_ABS: begin
        jump = 1'b1;
      end
      OP_OR_LIT_ACC: begin
        result = acc_val | lit;
        to_acc = 1'b1;
        upd_zero = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  // Zero flag value from the 8-bit result
  assign zero_val = (result == 8'h00);

endmodule

`default_nettype wire

// [mise_core.sv]
// Execution unit for a subset of 8-bit core instructions, with APB access
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module mise_core
  import mise_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  // Instruction issue
  input wire logic instr_valid,
  input wire mise_op_t instr_op,
  input wire logic [6:0] instr_file,
  input wire logic instr_dest,
  input wire logic [10:0] instr_lit,
  output logic instr_ready_q,
  // Data register file
  output logic [6:0] rf_addr_q,
  input wire logic [7:0] rf_rdata,
  output logic [7:0] rf_wdata_q,
  output logic rf_we_q,
  // Core state
  output logic [12:0] pc_q,
  output logic [7:0] acc_q,
  output logic zero_q,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mise_state_t state_q, state_d;
  mise_op_t hold_op_q, hold_op_d;
  logic hold_dest_q, hold_dest_d;
  logic [10:0] hold_lit_q, hold_lit_d;
  logic squash_q, squash_d;
  logic instr_ready_d;
  logic [6:0] rf_addr_d;
  logic [7:0] rf_wdata_d;
  logic rf_we_d;
  logic [12:0] pc_d;
  logic [7:0] acc_d;
  logic zero_d;
  logic [7:0] ulatch_q, ulatch_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic accept;
  logic exec;
  logic apb_wr;
  logic [7:0] alu_result;
  logic alu_to_acc, alu_to_file, alu_upd_zero, alu_zero, alu_skip, alu_jump;

  assign accept = instr_valid & instr_ready_q;
  assign exec = (state_q == ST_EXEC);
  assign apb_wr = psel & penable & pready_q & pwrite;

  // ----------------------------------------------------------------
  // Datapath for the held instruction
  // ----------------------------------------------------------------
  mise_alu u_alu (
    .op(hold_op_q),
    .dest(hold_dest_q),
    .file_val(rf_rdata),
    .acc_val(acc_q),
    .lit(hold_lit_q[7:0]),
    .result(alu_result),
    .to_acc(alu_to_acc),
    .to_file(alu_to_file),
    .upd_zero(alu_upd_zero),
    .zero_val(alu_zero),
    .skip_next(alu_skip),
    .jump(alu_jump)
  );

  // ----------------------------------------------------------------
  // Issue and execution sequencing
  // ----------------------------------------------------------------
  // Accept in idle, execute the cycle after; squashed slot runs as a no-op
  always_comb begin
    state_d = state_q;
    hold_op_d = hold_op_q;
    hold_dest_d = hold_dest_q;
    hold_lit_d = hold_lit_q;
    squash_d = squash_q;
    rf_addr_d = rf_addr_q;
    rf_wdata_d = rf_wdata_q;
    rf_we_d = 1'b0;
    pc_d = pc_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_EXEC;
          hold_op_d = squash_q ? OP_NOP : instr_op;
          hold_dest_d = instr_dest;
          hold_lit_d = instr_lit;
          rf_addr_d = instr_file;
        end
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
        rf_we_d = alu_to_file;
        rf_wdata_d = alu_result;
        squash_d = alu_skip | alu_jump;
        if (alu_jump) begin
          pc_d = {ulatch_q[MISE_ULATCH_HI:MISE_ULATCH_LO], hold_lit_q};
        end else begin
          pc_d = pc_q + 13'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    instr_ready_d = (state_d == ST_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      hold_op_q <= OP_NOP;
      hold_dest_q <= 1'b0;
      hold_lit_q <= 11'h000;
      squash_q <= 1'b0;
      instr_ready_q <= 1'b1;
      rf_addr_q <= 7'h00;
      rf_wdata_q <= 8'h00;
      rf_we_q <= 1'b0;
      pc_q <= MISE_PC_RST;
    end else begin
      state_q <= state_d;
      hold_op_q <= hold_op_d;
      hold_dest_q <= hold_dest_d;
      hold_lit_q <= hold_lit_d;
      squash_q <= squash_d;
      instr_ready_q <= instr_ready_d;
      rf_addr_q <= rf_addr_d;
      rf_wdata_q <= rf_wdata_d;
      rf_we_q <= rf_we_d;
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, zero flag and upper latch
  // ----------------------------------------------------------------
  // Software writes first; an executing instruction overrides them
  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    ulatch_d = ulatch_q;
    if (apb_wr) begin
      case (paddr)
        MISE_OFF_ACC: acc_d = pwdata[7:0];
        MISE_OFF_STATUS: zero_d = pwdata[MISE_STAT_ZERO_BIT];
        MISE_OFF_ULATCH: ulatch_d = pwdata[7:0];
        default: acc_d = acc_q;
      endcase
    end
    if (exec && alu_to_acc) begin
      acc_d = alu_result;
    end
    if (exec && alu_upd_zero) begin
      zero_d = alu_zero;
    end
  end

  // Architectural state registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      acc_q <= MISE_ACC_RST;
      zero_q <= MISE_ZERO_RST;
      ulatch_q <= MISE_ULATCH_RST;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      ulatch_q <= ulatch_d;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Ready one cycle into the access phase, read data captured alongside
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel && penable && !pready_q) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      case (paddr)
        MISE_OFF_ACC: prdata_d[7:0] = acc_q;
        MISE_OFF_STATUS: begin
          prdata_d[MISE_STAT_ZERO_BIT] = zero_q;
          prdata_d[MISE_STAT_SQUASH_BIT] = squash_q;
        end
        MISE_OFF_ULATCH: prdata_d[7:0] = ulatch_q;
        MISE_OFF_PC: prdata_d[12:0] = pc_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  clear_file_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_CLEAR_FILE |=> rf_we_q && rf_wdata_q == 8'h00 && zero_q)
    else $error("clear file did not write zero or set zero flag");

  dec_file_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_DEC_FILE |=>
      ($past(hold_dest_q) ? (rf_we_q && rf_wdata_q == 8'($past(rf_rdata) - 8'h01))
                          : (acc_q == 8'($past(rf_rdata) - 8'h01) && !rf_we_q))
      && zero_q == ($past(rf_rdata) == 8'h01))
    else $error("decrement result or zero flag wrong");

  clear_acc_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_CLEAR_ACC |=> acc_q == 8'h00 && zero_q && !rf_we_q)
    else $error("clear accumulator failed");

  dec_skip_dest_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_DEC_SKIP && !hold_dest_q && !apb_wr |=>
      acc_q == 8'($past(rf_rdata) - 8'h01) && $stable(zero_q) && !rf_we_q)
    else $error("decrement-skip routing or flag wrong");

  dec_skip_sq_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_DEC_SKIP |=> squash_q == ($past(rf_rdata) == 8'h01))
    else $error("decrement-skip squash decision wrong");

  inc_skip_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_INC_SKIP && !apb_wr |=>
      squash_q == ($past(rf_rdata) == 8'hff) && $stable(zero_q))
    else $error("increment-skip squash or flag wrong");

  jump_pc_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_JUMP_ABS |=>
      pc_q == {$past(ulatch_q[4:3]), $past(hold_lit_q)})
    else $error("jump target wrong");

  jump_flush_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_JUMP_ABS && !apb_wr |=>
      squash_q && $stable(zero_q) && $stable(acc_q) && !rf_we_q)
    else $error("jump altered state or did not arm the discard");

  or_lit_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_OR_LIT_ACC |=>
      acc_q == ($past(acc_q) | $past(hold_lit_q[7:0])) && zero_q == (acc_q == 8'h00))
    else $error("or literal result or zero flag wrong");

  zero_flag_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    exec && hold_op_q == OP_DEC_FILE |=>
      zero_q == (($past(hold_dest_q) ? rf_wdata_q : acc_q) == 8'h00))
    else $error("zero flag does not follow the result");

  squash_nop_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    accept && squash_q |=> hold_op_q == OP_NOP ##1 !rf_we_q && $stable(acc_q) && !squash_q)
    else $error("squashed slot had an effect");

endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the instruction-subset execution block
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import mise_pkg::*;
;
  typedef struct packed {
    logic [7:0] acc;
    logic zero;
    logic [12:0] pc;
    logic we;
    logic [7:0] wdata;
    logic [6:0] addr;
  } mise_exp_t;
  typedef struct packed {logic rd; logic [31:0] data; logic err;} mise_apb_t;

  logic core_clk, rst_b, instr_valid, instr_dest, instr_ready_q, rf_we_q, zero_q;
  mise_op_t instr_op;
  logic [6:0] instr_file, rf_addr_q;
  logic [10:0] instr_lit;
  logic [7:0] rf_rdata, rf_wdata_q, acc_q, paddr;
  logic [12:0] pc_q;
  logic psel, penable, pwrite, pready_q, pslverr_q;
  logic [31:0] pwdata, prdata_q, rng, rv;
  logic [7:0] mem [128];
  logic [7:0] m_mem [128];
  logic [7:0] m_acc, m_ul;
  logic [12:0] m_pc;
  logic m_zero, m_sq;
  int miscompares, n_checks;
  mise_exp_t exp_q [$];
  mise_apb_t apb_q [$];

  mise_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_file(instr_file), .instr_dest(instr_dest), .instr_lit(instr_lit), .instr_ready_q(instr_ready_q),
    .rf_addr_q(rf_addr_q), .rf_rdata(rf_rdata), .rf_wdata_q(rf_wdata_q), .rf_we_q(rf_we_q), .pc_q(pc_q),
    .acc_q(acc_q), .zero_q(zero_q), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q));

  // ----------------------------------------------------------------
  // Clock and register file
  // ----------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  assign rf_rdata = mem[rf_addr_q];
  // File writes at the edge the strobe is seen
  always @(posedge core_clk) begin
    if (rf_we_q === 1'b1) mem[rf_addr_q] <= rf_wdata_q;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reference model, expectation note, then the issue handshake
  task automatic exec(input mise_op_t op, input logic [6:0] f, input logic d, input logic [10:0] k);
    mise_exp_t e;
    logic [7:0] r;
    int n;
    e = '0;
    r = m_mem[f];
    if (m_sq) begin
      m_sq = 1'b0;
      m_pc = m_pc + 13'h0001;
    end else begin
      m_pc = (op == OP_JUMP_ABS) ? {m_ul[4:3], k} : m_pc + 13'h0001;
      case (op)
        OP_CLEAR_FILE: begin
          r = 8'h00;
          e.we = 1'b1;
          m_zero = 1'b1;
        end
        OP_CLEAR_ACC: begin
          m_acc = 8'h00;
          m_zero = 1'b1;
        end
        OP_DEC_FILE, OP_DEC_SKIP, OP_INC_SKIP: begin
          r = (op == OP_INC_SKIP) ? r + 8'h01 : r - 8'h01;
          if (d) e.we = 1'b1;
          else m_acc = r;
          if (op == OP_DEC_FILE) m_zero = (r == 8'h00);
          else m_sq = (r == 8'h00);
        end
        OP_JUMP_ABS: m_sq = 1'b1;
        OP_OR_LIT_ACC: begin
          m_acc = m_acc | k[7:0];
          m_zero = (m_acc == 8'h00);
        end
        default: ;
      endcase
      if (e.we) m_mem[f] = r;
    end
    e.wdata = r;
    e.addr = f;
    e.acc = m_acc;
    e.zero = m_zero;
    e.pc = m_pc;
    exp_q.push_back(e);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_file <= f;
    instr_dest <= d;
    instr_lit <= k;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (instr_ready_q !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end else begin
      instr_valid <= 1'b0;
    end
  endtask

  // One APB transfer, waiting for the slave's ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] want,
    input logic err);
    int n;
    apb_q.push_back('{~wr, want, err});
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready_q !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Result monitors
  // ----------------------------------------------------------------
  // Outputs settle at the edge after the take
  initial begin
    mise_exp_t e;
    forever begin
      @(posedge core_clk);
      if (instr_valid === 1'b1 && instr_ready_q === 1'b1) begin
        @(posedge core_clk);
        #1;
        e = exp_q.pop_front();
        check(acc_q, e.acc);
        check(zero_q, e.zero);
        check(pc_q, e.pc);
        check(rf_we_q, e.we);
        if (e.we) check(rf_wdata_q, e.wdata);
        check(rf_addr_q, e.addr);
      end
    end
  end

  // Read data and error at the completing edge
  always @(posedge core_clk) begin
    mise_apb_t a;
    if (psel === 1'b1 && penable === 1'b1 && pready_q === 1'b1) begin
      a = apb_q.pop_front();
      check(pslverr_q, a.err);
      if (a.rd) check(prdata_q, a.data);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {instr_valid, instr_dest, psel, penable, pwrite} = '0;
    instr_op = OP_NOP;
    {instr_file, instr_lit, paddr, pwdata} = '0;
    {m_acc, m_ul, m_pc, m_zero, m_sq, miscompares, n_checks} = '0;
    rng = 32'h0000_0011;
    for (int i = 0; i < 128; i++) begin
      rv = rnd();
      mem[i] = rv[7:0];
    end
    mem[1] = 8'h01;
    mem[2] = 8'hff;
    mem[3] = 8'h01;
    for (int i = 0; i < 128; i++) m_mem[i] = mem[i];
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, MISE_OFF_ACC, 32'h0, 32'h0, 1'b0);
    apb(1'b0, MISE_OFF_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, MISE_OFF_PC, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    exec(OP_CLEAR_FILE, 7'h7f, 1'b0, 11'h000);
    exec(OP_DEC_FILE, 7'h03, 1'b0, 11'h000);
    exec(OP_DEC_FILE, 7'h03, 1'b1, 11'h000);
    exec(OP_OR_LIT_ACC, 7'h00, 1'b0, 11'h700);
    exec(OP_OR_LIT_ACC, 7'h00, 1'b0, 11'h05a);
    exec(OP_CLEAR_ACC, 7'h00, 1'b0, 11'h000);
    exec(OP_DEC_SKIP, 7'h01, 1'b1, 11'h000);
    exec(OP_OR_LIT_ACC, 7'h00, 1'b0, 11'h0ff);
    exec(OP_INC_SKIP, 7'h02, 1'b0, 11'h000);
    exec(OP_CLEAR_FILE, 7'h05, 1'b1, 11'h000);
    exec(OP_DEC_SKIP, 7'h03, 1'b0, 11'h000);
    apb(1'b1, MISE_OFF_ULATCH, 32'h18, 32'h0, 1'b0);
    m_ul = 8'h18;
    exec(OP_JUMP_ABS, 7'h00, 1'b0, 11'h7ff);
    apb(1'b0, MISE_OFF_STATUS, 32'h0, {30'h0, m_sq, m_zero}, 1'b0);
    exec(OP_DEC_FILE, 7'h09, 1'b1, 11'h000);
    exec(OP_INC_SKIP, 7'h09, 1'b0, 11'h000);
    apb(1'b1, MISE_OFF_ACC, 32'h3c, 32'h0, 1'b0);
    m_acc = 8'h3c;
    for (int i = 0; i < 60; i++) begin
      rv = rnd();
      exec(mise_op_t'(rv[2:0]), rv[9:3], rv[10], rv[21:11]);
    end
    apb(1'b0, MISE_OFF_ACC, 32'h0, {24'h0, m_acc}, 1'b0);
    apb(1'b0, MISE_OFF_PC, 32'h0, {19'h0, m_pc}, 1'b0);
    // Let the monitors take the last answers before closing
    repeat (2) @(posedge core_clk);
    check(exp_q.size(), 0);
    check(apb_q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
